// ### core/tzc_pkg.sv
// package: register map, field layout and reset values of the timer zero control block
`default_nettype none
package tzc_pkg;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [3:0] TZC_CTRL_A_OFF = 4'h0;
    localparam logic [3:0] TZC_COUNT_OFF = 4'h4;
    localparam logic [3:0] TZC_PERIOD_OFF = 4'h8;
    // ----------------------------------------------------------------
    // fields of the control register
    // ----------------------------------------------------------------
    localparam int TZC_EN_BIT = 7;
    localparam int TZC_OUT_BIT = 5;
    localparam int TZC_WIDTH_BIT = 4;
    localparam int TZC_PS_LSB = 0;
    localparam int TZC_PS_W = 4;
    localparam logic [7:0] TZC_CTRL_A_RST = 8'h00;
    localparam logic [7:0] TZC_CTRL_A_WMASK = 8'h9F;
    localparam logic [15:0] TZC_PERIOD_RST = 16'hFFFF;
    localparam logic [15:0] TZC_COUNT_RST = 16'h0000;
    localparam logic [3:0] TZC_PS_RST = 4'h0;
    localparam logic [1:0] TZC_RESP_OKAY = 2'b00;
    localparam logic [1:0] TZC_RESP_SLVERR = 2'b10;
endpackage
`default_nettype wire

// ### core/tzc_post_if.sv
// interface: period events into the postscaler and its toggle back out
`default_nettype none
interface tzc_post_if;
    logic run;
    logic period_hit;
    logic [3:0] ratio;
    logic out_level;
    modport core (output run, output period_hit, output ratio, input out_level);
    modport post (input run, input period_hit, input ratio, output out_level);
endinterface
`default_nettype wire

// ### core/tzc_postscaler.sv
// module: output postscaler that toggles the timer output every n period events
`default_nettype none
module tzc_postscaler
    import tzc_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // link to the timer core
    tzc_post_if.post pif
);
    logic [3:0] ps_cnt_q;
    logic out_q;

    assign pif.out_level = out_q;

    // ----------------------------------------------------------------
    // event count and toggle
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset || !pif.run) begin
            ps_cnt_q <= TZC_PS_RST;
        end else if (pif.period_hit) begin
            // ratio field plus one events per toggle
            if (ps_cnt_q >= pif.ratio) begin // [RQ4]
                ps_cnt_q <= TZC_PS_RST; // [RQ5]
            end else begin
                ps_cnt_q <= ps_cnt_q + 4'h1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        // output holds its level while disabled, cleared only by reset
        if (reset) begin
            out_q <= 1'b0;
        end else if (pif.run && pif.period_hit && ps_cnt_q >= pif.ratio) begin
            out_q <= ~out_q; // [RQ5]
        end
    end
endmodule
`default_nettype wire

// ### core/tzc_top.sv
// module: timer zero control block with its AXI4-Lite register slave
// Contract
// [RQ1] enable runs timer; clear stops it, low power
// [RQ2] output bit readable, writes to it ignored
// [RQ3] width select: one 16-bit, zero 8-bit
// [RQ4] postscale divides events by field plus one
// [RQ5] toggle output after postscale count, then restart
//
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`default_nettype none
module tzc_top
    import tzc_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // axi4-lite write address
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // timer
    input wire logic timer_tick,
    output logic timer_out
);
    logic [7:0] ctrl_a_q;
    logic [15:0] period_q;
    logic [15:0] timer_zero_counter_q;
    logic [3:0] aw_addr_q;
    logic aw_have_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic w_have_q;
    logic tick_s1_q;
    logic tick_s2_q;
    logic tick_s3_q;
    logic out_q;
    logic enable;
    logic counter_width_select;
    logic [3:0] output_postscale_select;
    logic tick_rise;
    logic period_hit;
    logic wr_fire;
    logic [15:0] limit;
    tzc_post_if pif ();

    assign enable = ctrl_a_q[TZC_EN_BIT];
    assign counter_width_select = ctrl_a_q[TZC_WIDTH_BIT];
    assign output_postscale_select = ctrl_a_q[TZC_PS_LSB +: TZC_PS_W];

    // ----------------------------------------------------------------
    // timer tick from the selected clock, synchronised
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            tick_s1_q <= 1'b0;
            tick_s2_q <= 1'b0;
            tick_s3_q <= 1'b0;
        end else begin
            tick_s1_q <= timer_tick;
            tick_s2_q <= tick_s1_q;
            tick_s3_q <= tick_s2_q;
        end
    end
    assign tick_rise = tick_s2_q && !tick_s3_q;

    // ----------------------------------------------------------------
    // counter
    // ----------------------------------------------------------------
    // in 8-bit mode only the low byte of the period is compared
    assign limit = counter_width_select ? period_q : {8'h00, period_q[7:0]}; // [RQ3]
    assign period_hit = enable && tick_rise && (timer_zero_counter_q == limit);

    always_ff @(posedge mclk) begin
        if (reset) begin
            timer_zero_counter_q <= TZC_COUNT_RST;
        end else if (!enable) begin
            // held at zero: no toggling logic while disabled
            timer_zero_counter_q <= TZC_COUNT_RST; // [RQ1]
        end else if (tick_rise) begin
            if (period_hit) begin
                timer_zero_counter_q <= TZC_COUNT_RST;
            end else if (counter_width_select) begin
                timer_zero_counter_q <= timer_zero_counter_q + 16'h0001; // [RQ3]
            end else begin
                timer_zero_counter_q <= {8'h00, timer_zero_counter_q[7:0] + 8'h01}; // [RQ3]
            end
        end
    end

    assign pif.run = enable; // [RQ1]
    assign pif.period_hit = period_hit;
    assign pif.ratio = output_postscale_select;

    tzc_postscaler u_post (
        .mclk(mclk),
        .reset(reset),
        .pif(pif)
    );

    always_ff @(posedge mclk) begin
        if (reset) begin
            out_q <= 1'b0;
        end else begin
            out_q <= pif.out_level;
        end
    end
    assign timer_out = out_q;

    // ----------------------------------------------------------------
    // axi4-lite write path
    // ----------------------------------------------------------------
    assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

    always_ff @(posedge mclk) begin
        if (reset) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= 4'h0;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_have_q && !s_axi_awready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (wr_fire) begin
                aw_have_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            w_have_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_have_q && !s_axi_wready;
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (wr_fire) begin
                w_have_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= TZC_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr_q == TZC_CTRL_A_OFF || aw_addr_q == TZC_PERIOD_OFF ||
                            aw_addr_q == TZC_COUNT_OFF) ? TZC_RESP_OKAY : TZC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            ctrl_a_q <= TZC_CTRL_A_RST;
        end else if (wr_fire && aw_addr_q == TZC_CTRL_A_OFF && w_strb_q[0]) begin
            // the output bit and bit 6 are not storage and ignore writes
            ctrl_a_q <= w_data_q[7:0] & TZC_CTRL_A_WMASK; // [RQ2]
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            period_q <= TZC_PERIOD_RST;
        end else if (wr_fire && aw_addr_q == TZC_PERIOD_OFF) begin
            if (w_strb_q[0]) begin
                period_q[7:0] <= w_data_q[7:0];
            end
            if (w_strb_q[1]) begin
                period_q[15:8] <= w_data_q[15:8];
            end
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite read path
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= TZC_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !s_axi_arvalid;
            if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
                s_axi_arready <= 1'b1;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= TZC_RESP_OKAY;
                unique case (s_axi_araddr)
                    TZC_CTRL_A_OFF: begin
                        s_axi_rdata <= {24'h000000, ctrl_a_q[7:6], out_q, ctrl_a_q[4:0]}; // [RQ2]
                    end
                    TZC_COUNT_OFF: begin
                        s_axi_rdata <= {16'h0000, timer_zero_counter_q};
                    end
                    TZC_PERIOD_OFF: begin
                        s_axi_rdata <= {16'h0000, period_q};
                    end
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= TZC_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ### sim/tzc_assertions.sv
// checker: bus handshake and register read properties of timer zero control
`default_nettype none
module tzc_assertions
    import tzc_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // register bus
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // timer
    input wire logic timer_out
);
    // ------
    // properties
    // ------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    AST_AR_PULSE: assert property (s_axi_arready |=> !s_axi_arready)
        else $error("arready held");
    AST_W_PULSE: assert property (s_axi_wready |=> !s_axi_wready)
        else $error("wready held");
    AST_B_LAT: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("no write response");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("response dropped");
    AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read data");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    AST_BAD_RD: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[3:2] == 2'h3
        |=> s_axi_rresp == TZC_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad read");
    // upper bytes and bit 6 read zero; the output bit reads back the timer output
    AST_CTRL_RD: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr == TZC_CTRL_A_OFF |=>
        s_axi_rdata[31:8] == 24'h0 && !s_axi_rdata[6] && s_axi_rdata[5] == $past(timer_out))
        else $error("control read wrong");
    // each of the three mapped offsets answers a read with okay
    AST_GOOD_RD: assert property (s_axi_arvalid && s_axi_arready &&
        (s_axi_araddr == TZC_CTRL_A_OFF || s_axi_araddr == TZC_COUNT_OFF ||
        s_axi_araddr == TZC_PERIOD_OFF) |=> s_axi_rresp == TZC_RESP_OKAY)
        else $error("mapped read refused");
endmodule
bind tzc_top tzc_assertions u_tzc_assertions (
    .mclk, .reset, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_out
);
`default_nettype wire

// ### sim/test_timer_zero_control.sv
// testbench: register access and timer output of timer zero control
`default_nettype none
module test_timer_zero_control import tzc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'h0, reset = 1'h1, timer_tick = 1'h0, timer_out, x = 1'h0;
    logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
    logic s_axi_arvalid = '0, s_axi_rready = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd, p;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    int fail_count = 0, checks = 0, cyc = 0;
    tzc_top u_tzc_top (
        .mclk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_tick, .timer_out
    );
    // ------
    // clock, timeout and reporting
    // ------
    always #4 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            final_report();
        end
    end
    task automatic final_report;
        $display("mismatches %0d checks %0d", fail_count, checks);
        if (fail_count == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // ------
    // bus and tick drivers; ready stalls are random
    // ------
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            // once raised, bready stays up until the response is taken
            if (!s_axi_bready && $urandom_range(1)) s_axi_bready <= 1'h1;
        end while (!(s_axi_bvalid && s_axi_bready));
        rsp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic rdr(input logic [3:0] a);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (!s_axi_rready && $urandom_range(1)) s_axi_rready <= 1'h1;
        end while (!(s_axi_rvalid && s_axi_rready));
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    task automatic wok(input logic [3:0] a, input logic [31:0] d);
        wr(a, d);
        chk(rsp, TZC_RESP_OKAY);
    endtask
    task automatic rchk(input logic [3:0] a, input logic [31:0] e);
        rdr(a);
        chk({rsp, rd}, {TZC_RESP_OKAY, e});
    endtask
    // each tick is 4 cycles high, 4 low; the tail covers synchroniser and toggle delay
    task automatic tick(input int n);
        repeat (n) begin
            repeat (4) @(posedge mclk);
            timer_tick <= 1'h1;
            repeat (4) @(posedge mclk);
            timer_tick <= 1'h0;
        end
        repeat (8) @(posedge mclk);
    endtask
    initial begin
        void'($urandom(32'hA500D7C1));
        repeat (4) @(posedge mclk);
        reset <= 1'h0;
        rchk(TZC_CTRL_A_OFF, 32'h0);
        rchk(TZC_PERIOD_OFF, 32'hFFFF);
        rchk(TZC_COUNT_OFF, 32'h0);
        wok(TZC_CTRL_A_OFF, 32'hFF);
        rchk(TZC_CTRL_A_OFF, 32'h9F);
        wr(4'hC, 32'h5A);
        chk(rsp, TZC_RESP_SLVERR);
        rdr(4'hC);
        chk({rsp, rd}, {TZC_RESP_SLVERR, 32'h0});
        wok(TZC_PERIOD_OFF, 32'h00FF);
        wok(TZC_CTRL_A_OFF, 32'h80);
        tick(5);
        rchk(TZC_COUNT_OFF, 32'h5);
        wok(TZC_CTRL_A_OFF, 32'h0);
        tick(4);
        rchk(TZC_COUNT_OFF, 32'h0);
        // low byte alone would wrap after three ticks in the narrow mode
        wok(TZC_PERIOD_OFF, 32'h0102);
        wok(TZC_CTRL_A_OFF, 32'h90);
        tick(3);
        rchk(TZC_COUNT_OFF, 32'h3);
        chk(timer_out, x);
        for (int c = 0; c < 16; c++) begin
            p = $urandom & 32'hFF03;
            wok(TZC_CTRL_A_OFF, 32'h0);
            wok(TZC_PERIOD_OFF, p);
            wok(TZC_CTRL_A_OFF, 32'h80 | c);
            tick((p[7:0] + 1) * (c + 1) - 1);
            chk(timer_out, x);
            x = !x;
            tick(1);
            chk(timer_out, x);
            rchk(TZC_CTRL_A_OFF, 32'h80 | c | (32'(x) << 5));
        end
        final_report();
    end
endmodule
`default_nettype wire
